// ===== rtl/ufi_irq_top.sv
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
// Contract
// - both enable registers clear on system or function software reset
// - first enable bit 7 reads zero, writes ignored
// - first enable bit 6 gates fifo read request interrupt
// - first enable bit 5 gates bus reset interrupt
// - first enable bit 4 gates start of frame interrupt
// - first enable bit 3 gates both suspend exit and entry
// - first enable bit 2 gates abnormal completion interrupt
// - first enable bit 1 gates normal completion interrupt
// - first enable bit 0 gates setup interrupt
// - second enable bits 7..2 read zero, writes ignored
// - second enable bit 1 gates set configuration interrupt
// - second enable bit 0 gates set interface interrupt
// - four request lines; first carries only setup
// - lines two and three each select normal or abnormal completion
// - fourth line carries all remaining enabled sources
// - both flag registers clear on system or function software reset
// - first flag bit 7 is OR of endpoint normal flags
// - normal summary and its enable request the fourth line
// - first flag bit 6 shows abnormal completion somewhere
// - abnormal summary is OR of endpoint abnormal flags
// - abnormal summary and its enable request the fourth line
module ufi_irq_top
    import ufi_pkg::*;
(
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         reset_in,
    // axi4-lite write
    input  wire logic [7:0]   awaddr_in,
    input  wire logic         awvalid_in,
    output logic              awready_out,
    input  wire logic [31:0]  wdata_in,
    input  wire logic [3:0]   wstrb_in,
    input  wire logic         wvalid_in,
    output logic              wready_out,
    output logic [1:0]        bresp_out,
    output logic              bvalid_out,
    input  wire logic         bready_in,
    // axi4-lite read
    input  wire logic [7:0]   araddr_in,
    input  wire logic         arvalid_in,
    output logic              arready_out,
    output logic [31:0]       rdata_out,
    output logic [1:0]        rresp_out,
    output logic              rvalid_out,
    input  wire logic         rready_in,
    // function core side
    input  wire ufi_core_ev_t core_in,
    output ufi_irq_t          irq_out
);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic [7:0] flg_a;
    logic [4:0] flg_ev;
    logic [2:0] flg_sum;
    logic [7:0] flg_b;
    logic [1:0] route;
    logic       func_rst;
    logic       clr;
    logic       aw_full;
    logic       w_full;
    logic [7:0] aw_addr;
    logic [7:0] w_byte;
    logic       w_lane0;
    logic       do_write;
    logic       next_aw_full;
    logic       next_w_full;
    logic       ok_sum;
    logic       err_sum;
    logic       fifo_sum;
    logic [7:0] flg_a_view;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == ADDR_EN_A) || (a == ADDR_EN_B) || (a == ADDR_FLG_A) ||
                 (a == ADDR_FLG_B) || (a == ADDR_ROUTE) || (a == ADDR_CTRL);
    endfunction

    // byte lane 0 write to register at addr a
    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = do_write && w_lane0 && (aw_addr == a);
    endfunction

    assign clr          = reset_in | func_rst;
    assign do_write     = aw_full && w_full && !bvalid_out;
    assign next_aw_full = (aw_full && !do_write) || (awvalid_in && awready_out);
    assign next_w_full  = (w_full && !do_write) || (wvalid_in && wready_out);

    ////////////////////////////////////////////////////////////////////////
    // write channels: address and data taken in either order
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            aw_full     <= 1'b0;
            w_full      <= 1'b0;
            awready_out <= 1'b0;
            wready_out  <= 1'b0;
            aw_addr     <= 8'h00;
            w_byte      <= 8'h00;
            w_lane0     <= 1'b0;
        end else begin
            aw_full     <= next_aw_full;
            w_full      <= next_w_full;
            awready_out <= !next_aw_full;
            wready_out  <= !next_w_full;
            if (awvalid_in && awready_out) begin
                aw_addr <= {awaddr_in[7:2], 2'b00};
            end
            if (wvalid_in && wready_out) begin
                w_byte  <= wdata_in[7:0];
                w_lane0 <= wstrb_in[0];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            bvalid_out <= 1'b0;
            bresp_out  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_out <= 1'b1;
            bresp_out  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready_in) begin
            bvalid_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control state
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            func_rst <= 1'b0;
        end else begin
            func_rst <= wr_hit(ADDR_CTRL) && w_byte[BIT_FUNC_RST];
        end
    end

    // route survives the function reset so software need not reprogram it
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            route <= 2'b00;
        end else if (wr_hit(ADDR_ROUTE)) begin
            route <= w_byte[1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (clr) begin
            en_a <= EN_RESET;
            en_b <= EN_RESET;
        end else begin
            if (wr_hit(ADDR_EN_A)) begin
                en_a <= w_byte & EN_A_MASK;
            end
            if (wr_hit(ADDR_EN_B)) begin
                en_b <= w_byte & EN_B_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky flags: writing 0 clears a bit, an event in the same cycle wins
    always_ff @(posedge clk_in) begin
        if (clr) begin
            flg_ev <= FLG_RESET[4:0];
            flg_b  <= FLG_RESET;
        end else begin
            flg_ev <= (wr_hit(ADDR_FLG_A) ? (flg_ev & w_byte[4:0]) : flg_ev)
                    | {core_in.bus_reset_ev, core_in.frame_start_ev,
                       core_in.suspend_out_ev, core_in.suspend_in_ev,
                       core_in.setup_ev};
            flg_b  <= (wr_hit(ADDR_FLG_B) ? (flg_b & w_byte) : flg_b) & EN_B_MASK
                    | {6'h00, core_in.set_config_ev, core_in.set_intf_ev};
        end
    end

    // summaries follow the endpoint registers, which share the same reset
    always_ff @(posedge clk_in) begin
        if (clr) begin
            flg_sum <= FLG_RESET[7:5];
        end else begin
            flg_sum <= {|core_in.endpoint_ok_flags,
                        |core_in.endpoint_err_flags,
                        |core_in.fifo_req_flags};
        end
    end

    // summaries are read-only, so a flag write never reaches bits 7:5
    assign flg_a      = {flg_sum, flg_ev};
    assign ok_sum     = flg_a[FLG_OK];
    assign err_sum    = flg_a[FLG_ERR];
    assign fifo_sum   = flg_a[FLG_FIFO];
    assign flg_a_view = flg_a;

    ////////////////////////////////////////////////////////////////////////
    // read channel, answer one cycle after address taken
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            arready_out <= 1'b0;
            rvalid_out  <= 1'b0;
            rdata_out   <= 32'h0000_0000;
            rresp_out   <= RESP_OKAY;
        end else if (arvalid_in && arready_out) begin
            arready_out <= 1'b0;
            rvalid_out  <= 1'b1;
            rresp_out   <= mapped({araddr_in[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
            case ({araddr_in[7:2], 2'b00})
                ADDR_EN_A:  rdata_out <= {24'h00_0000, en_a};
                ADDR_EN_B:  rdata_out <= {24'h00_0000, en_b};
                ADDR_FLG_A: rdata_out <= {24'h00_0000, flg_a_view};
                ADDR_FLG_B: rdata_out <= {24'h00_0000, flg_b};
                ADDR_ROUTE: rdata_out <= {30'h0000_0000, route};
                default:    rdata_out <= 32'h0000_0000;
            endcase
        end else if (rvalid_out) begin
            if (rready_in) begin
                rvalid_out  <= 1'b0;
                arready_out <= 1'b1;
            end
        end else begin
            arready_out <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request lines, levels held while any gated source is active
    always_ff @(posedge clk_in) begin
        if (clr) begin
            irq_out <= '0;
        end else begin
            irq_out.irq_line_setup  <= flg_a[0] && en_a[BIT_SETUP];
            irq_out.irq_line_xfer_b <= route[BIT_ROUTE_B] ?
                                       (err_sum && en_a[BIT_ERR]) : (ok_sum && en_a[BIT_OK]);
            irq_out.irq_line_xfer_c <= route[BIT_ROUTE_C] ?
                                       (err_sum && en_a[BIT_ERR]) : (ok_sum && en_a[BIT_OK]);
            irq_out.irq_line_misc   <=
                (ok_sum && en_a[BIT_OK])
              | (err_sum && en_a[BIT_ERR])
              | (fifo_sum && en_a[BIT_FIFO])
              | (flg_a[FLG_BRST] && en_a[BIT_BRST])
              | (flg_a[FLG_SOF] && en_a[BIT_SOF])
              | ((flg_a[FLG_SUSP_OUT] | flg_a[FLG_SUSP_IN]) && en_a[BIT_SUSP])
              | (flg_b[BIT_SET_CFG] && en_b[BIT_SET_CFG])
              | (flg_b[BIT_SET_INTF] && en_b[BIT_SET_INTF]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    en_clear_a: assert property (
        $past(func_rst) |-> en_a == 8'h00 && en_b == 8'h00)
        else $error("enables not cleared by function reset");
    flg_clear_a: assert property (
        $past(func_rst) |-> flg_b == 8'h00 && flg_a[4:0] == 5'h00)
        else $error("flags not cleared by function reset");
    en_a_rsv_a: assert property (en_a[7] == 1'b0)
        else $error("reserved enable bit set");
    en_b_rsv_a: assert property (en_b[7:2] == 6'h00)
        else $error("reserved enable bits set");
    ok_sum_a: assert property (
        !func_rst |=> ok_sum == |$past(core_in.endpoint_ok_flags))
        else $error("normal summary wrong");
    err_sum_a: assert property (
        !func_rst |=> err_sum == |$past(core_in.endpoint_err_flags))
        else $error("abnormal summary wrong");
    ok_misc_a: assert property (
        ok_sum && en_a[BIT_OK] && !func_rst |=> irq_out.irq_line_misc)
        else $error("normal completion did not raise fourth line");
    err_misc_a: assert property (
        err_sum && en_a[BIT_ERR] && !func_rst |=> irq_out.irq_line_misc)
        else $error("abnormal completion did not raise fourth line");
    setup_line_a: assert property (
        irq_out.irq_line_setup |-> $past(flg_a[0] && en_a[BIT_SETUP]))
        else $error("setup line without enabled setup flag");
    route_b_a: assert property (
        route[BIT_ROUTE_B] && !err_sum && !func_rst ##1 !err_sum
        |-> !irq_out.irq_line_xfer_b)
        else $error("line two raised without abnormal source");
    set_wins_a: assert property (
        core_in.setup_ev && !func_rst |=> flg_a[0])
        else $error("setup event lost");

    // each gated source raises its line, and nothing else raises the first or fourth line
    setup_raise_a: assert property (
        flg_a[0] && en_a[BIT_SETUP] && !func_rst |=> irq_out.irq_line_setup)
        else $error("enabled setup flag did not raise first line");
    setup_gate_a: assert property (
        !(flg_a[0] && en_a[BIT_SETUP]) |=> !irq_out.irq_line_setup)
        else $error("first line raised while setup blocked");
    fifo_misc_a: assert property (
        fifo_sum && en_a[BIT_FIFO] && !func_rst |=> irq_out.irq_line_misc)
        else $error("fifo request did not raise fourth line");
    brst_misc_a: assert property (
        flg_a[FLG_BRST] && en_a[BIT_BRST] && !func_rst |=> irq_out.irq_line_misc)
        else $error("bus reset did not raise fourth line");
    sof_misc_a: assert property (
        flg_a[FLG_SOF] && en_a[BIT_SOF] && !func_rst |=> irq_out.irq_line_misc)
        else $error("frame start did not raise fourth line");
    susp_misc_a: assert property (
        (flg_a[FLG_SUSP_OUT] || flg_a[FLG_SUSP_IN]) && en_a[BIT_SUSP] && !func_rst
        |=> irq_out.irq_line_misc)
        else $error("suspend change did not raise fourth line");
    cfg_misc_a: assert property (
        flg_b[BIT_SET_CFG] && en_b[BIT_SET_CFG] && !func_rst |=> irq_out.irq_line_misc)
        else $error("set configuration did not raise fourth line");
    intf_misc_a: assert property (
        flg_b[BIT_SET_INTF] && en_b[BIT_SET_INTF] && !func_rst |=> irq_out.irq_line_misc)
        else $error("set interface did not raise fourth line");
    misc_quiet_a: assert property (
        !(ok_sum && en_a[BIT_OK]) && !(err_sum && en_a[BIT_ERR])
        && !(fifo_sum && en_a[BIT_FIFO]) && !(flg_a[FLG_BRST] && en_a[BIT_BRST])
        && !(flg_a[FLG_SOF] && en_a[BIT_SOF])
        && !((flg_a[FLG_SUSP_OUT] || flg_a[FLG_SUSP_IN]) && en_a[BIT_SUSP])
        && !(flg_b[BIT_SET_CFG] && en_b[BIT_SET_CFG])
        && !(flg_b[BIT_SET_INTF] && en_b[BIT_SET_INTF])
        |=> !irq_out.irq_line_misc)
        else $error("fourth line raised with no enabled source");
    route_c_a: assert property (
        route[BIT_ROUTE_C] && err_sum && en_a[BIT_ERR] && !func_rst
        |=> irq_out.irq_line_xfer_c)
        else $error("line three missed routed abnormal completion");
    route_b_ok_a: assert property (
        !route[BIT_ROUTE_B] && ok_sum && en_a[BIT_OK] && !func_rst
        |=> irq_out.irq_line_xfer_b)
        else $error("line two missed routed normal completion");

    // reserved bits as software sees them, and the bus answers standing
    rd_bit7_a: assert property (
        arvalid_in && arready_out && araddr_in[7:2] == ADDR_EN_A[7:2]
        |=> rdata_out[7] == 1'b0)
        else $error("reserved enable bit read as one");
    rd_bits_hi_a: assert property (
        arvalid_in && arready_out && araddr_in[7:2] == ADDR_EN_B[7:2]
        |=> rdata_out[7:2] == 6'h00)
        else $error("reserved enable bits read as one");
    bvalid_hold_a: assert property (
        bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
        else $error("write response dropped before handshake");
    rvalid_hold_a: assert property (
        rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
        else $error("read data dropped before handshake");

    misc_raise_c: cover property (!irq_out.irq_line_misc ##1 irq_out.irq_line_misc);
    route_c_c: cover property (route[BIT_ROUTE_C] && irq_out.irq_line_xfer_c);
    func_rst_c: cover property (func_rst ##1 en_a == 8'h00);
    setup_line_c: cover property (irq_out.irq_line_setup);
    route_mix_c: cover property (irq_out.irq_line_xfer_b && !irq_out.irq_line_xfer_c);

endmodule // ufi_irq_top

// ===== rtl/ufi_pkg.sv
package ufi_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_EN_A  = 8'h00;
    localparam logic [7:0] ADDR_EN_B  = 8'h04;
    localparam logic [7:0] ADDR_FLG_A = 8'h08;
    localparam logic [7:0] ADDR_FLG_B = 8'h0c;
    localparam logic [7:0] ADDR_ROUTE = 8'h10;
    localparam logic [7:0] ADDR_CTRL  = 8'h14;

    // reset values and writable masks
    localparam logic [7:0] EN_RESET   = 8'h00;
    localparam logic [7:0] FLG_RESET  = 8'h00;
    localparam logic [7:0] EN_A_MASK  = 8'h7f;
    localparam logic [7:0] EN_B_MASK  = 8'h03;

    // bit positions, first enable / first flag register
    localparam int BIT_SETUP   = 0;
    localparam int BIT_OK      = 1;
    localparam int BIT_ERR     = 2;
    localparam int BIT_SUSP    = 3;
    localparam int BIT_SOF     = 4;
    localparam int BIT_BRST    = 5;
    localparam int BIT_FIFO    = 6;
    localparam int FLG_SUSP_IN  = 1;
    localparam int FLG_SUSP_OUT = 2;
    localparam int FLG_SOF      = 3;
    localparam int FLG_BRST     = 4;
    localparam int FLG_FIFO     = 5;
    localparam int FLG_ERR      = 6;
    localparam int FLG_OK       = 7;
    // second enable / second flag register
    localparam int BIT_SET_INTF = 0;
    localparam int BIT_SET_CFG  = 1;
    // route register: 1 selects abnormal completion for that line
    localparam int BIT_ROUTE_B  = 0;
    localparam int BIT_ROUTE_C  = 1;
    // control register: write 1 for a function software reset
    localparam int BIT_FUNC_RST = 0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // events and per-endpoint flags from the function core
    typedef struct packed {
        logic [7:0] endpoint_ok_flags;
        logic [7:0] endpoint_err_flags;
        logic [7:0] fifo_req_flags;
        logic       setup_ev;
        logic       bus_reset_ev;
        logic       frame_start_ev;
        logic       suspend_out_ev;
        logic       suspend_in_ev;
        logic       set_config_ev;
        logic       set_intf_ev;
    } ufi_core_ev_t;

    typedef struct packed {
        logic irq_line_setup;
        logic irq_line_xfer_b;
        logic irq_line_xfer_c;
        logic irq_line_misc;
    } ufi_irq_t;
endpackage

// ===== tb/ufi_cpu_model.sv
`timescale 1ns/100ps
module ufi_cpu_model
    import ufi_pkg::*;
(
    // clock
    input  wire logic     clk_in,
    // request lines from the block
    input  wire ufi_irq_t irq_in,
    // line the cpu would service next, 3 also when idle
    output logic [1:0]    serve_out
);
    // fixed priority: routed completion lines ahead of the misc line
    always_ff @(posedge clk_in) begin
        if (irq_in.irq_line_setup) begin
            serve_out <= 2'h0;
        end else if (irq_in.irq_line_xfer_b) begin
            serve_out <= 2'h1;
        end else if (irq_in.irq_line_xfer_c) begin
            serve_out <= 2'h2;
        end else begin
            serve_out <= 2'h3;
        end
    end
endmodule // ufi_cpu_model

// ===== tb/usb_function_irq_enable_flags_tb.sv
`timescale 1ns/100ps
module usb_function_irq_enable_flags_tb
    import ufi_pkg::*;
;
    logic         clk_in, reset_in, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]   awaddr, araddr;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         awready, wready, bvalid, arready, rvalid;
    logic [1:0]   bresp, rresp, serve;
    logic [31:0]  rdata, x;
    ufi_core_ev_t core;
    ufi_irq_t     irq;
    logic [33:0]  expq[$];
    int           mismatches, checked;
    ufi_irq_top dut_u (.clk_in(clk_in), .reset_in(reset_in), .awaddr_in(awaddr),
        .awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata), .wstrb_in(wstrb),
        .wvalid_in(wvalid), .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid),
        .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready),
        .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready),
        .core_in(core), .irq_out(irq));
    ufi_cpu_model cpu_u (.clk_in(clk_in), .irq_in(irq), .serve_out(serve));
    always #10 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk_in);
        awaddr <= a; awvalid <= 1'b1; wdata <= {24'h0, d}; wvalid <= 1'b1; bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_in);
            if (awvalid && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; end
            if (wvalid && wready) begin w_ok = 1'b1; wvalid <= 1'b0; end
        end
        do @(posedge clk_in); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {32'h0, bresp}, {32'h0, (a > ADDR_CTRL) ? RESP_SLVERR : RESP_OKAY});
    endtask
    // expected word queued first, the monitor compares it when the answer lands
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        expq.push_back(e);
        @(posedge clk_in);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge clk_in); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_in); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask
    always @(posedge clk_in) begin
        if (rvalid === 1'b1 && rready) chk("rdata", {rresp, rdata}, expq.pop_front());
    end
    // lines settle two edges after a summary input, four leaves margin
    task automatic irq_is(input string n, input logic [3:0] e);
        repeat (4) @(posedge clk_in);
        chk(n, {30'h0, irq}, {30'h0, e});
    endtask
    task automatic pulse(input int i);
        @(posedge clk_in);
        core[i] <= 1'b1;
        @(posedge clk_in);
        core[i] <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] msk[7] = '{8'h01, 8'h02, 8'h08, 8'h08, 8'h10, 8'h20, 8'h01};
    logic [7:0] en_a, en_b, a, m;
    initial begin
        clk_in = 1'b0; reset_in = 1'b1; x = 32'h4cbc; core = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'h1;
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        for (int k = 0; k < 6; k++) rd(8'(4 * k), 34'h0);
        rd(8'h18, {RESP_SLVERR, 32'h0});
        wr(8'h18, 8'hff);
        $display("reset and map test done");
        repeat (4) begin
            en_a = 8'(rnd());
            en_b = 8'(rnd());
            wr(ADDR_EN_A, en_a);
            wr(ADDR_EN_B, en_b);
            rd(ADDR_EN_A, {26'h0, en_a & EN_A_MASK});
            rd(ADDR_EN_B, {26'h0, en_b & EN_B_MASK});
        end
        // a write without byte lane 0 is answered but changes nothing
        wstrb <= 4'h0;
        wr(ADDR_EN_A, 8'hff);
        wstrb <= 4'h1;
        rd(ADDR_EN_A, {26'h0, en_a & EN_A_MASK});
        $display("enable access test done");
        // event k: blocked with the other enables of its register on, then let through alone in that register
        for (int k = 0; k < 7; k++) begin
            a = (k < 2) ? ADDR_EN_B : ADDR_EN_A;
            m = msk[k];
            wr(a, ((k < 2) ? EN_B_MASK : EN_A_MASK) ^ m);
            pulse(k);
            irq_is("irq blocked", 4'h0);
            wr(a, m);
            irq_is("irq passed", (k == 6) ? 4'h8 : 4'h1);
            wr(ADDR_FLG_A, 8'h00);
            wr(ADDR_FLG_B, 8'h00);
            irq_is("irq cleared", 4'h0);
            wr(a, 8'h00);
        end
        $display("event gating test done");
        core.endpoint_ok_flags <= 8'(rnd() | 32'h1);
        wr(ADDR_EN_A, 8'h02);
        wr(ADDR_ROUTE, 8'h00);
        rd(ADDR_FLG_A, {26'h0, 8'h80});
        irq_is("irq ok route", 4'h7);
        chk("served line", {32'h0, serve}, 34'h1);
        wr(ADDR_ROUTE, 8'h03);
        irq_is("irq ok unrouted", 4'h1);
        core.endpoint_ok_flags <= 8'h00;
        core.endpoint_err_flags <= 8'(rnd() | 32'h1);
        wr(ADDR_EN_A, 8'h04);
        rd(ADDR_FLG_A, {26'h0, 8'h40});
        irq_is("irq err route", 4'h7);
        wr(ADDR_ROUTE, 8'h01);
        irq_is("irq mixed route", 4'h5);
        wr(ADDR_EN_A, 8'h02);
        irq_is("irq err masked", 4'h0);
        core.endpoint_err_flags <= 8'h00;
        core.fifo_req_flags <= 8'(rnd() | 32'h1);
        wr(ADDR_EN_A, 8'h40);
        irq_is("irq fifo", 4'h1);
        core.fifo_req_flags <= 8'h00;
        $display("summary test done");
        wr(ADDR_EN_A, 8'h7f);
        wr(ADDR_EN_B, 8'h03);
        pulse(5);
        pulse(1);
        irq_is("irq before reset", 4'h1);
        wr(ADDR_CTRL, 8'h01);
        irq_is("irq after reset", 4'h0);
        rd(ADDR_EN_A, 34'h0);
        rd(ADDR_EN_B, 34'h0);
        rd(ADDR_FLG_A, 34'h0);
        rd(ADDR_FLG_B, 34'h0);
        $display("software reset test done");
        repeat (4) @(posedge clk_in);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        stop_test();
    end
endmodule // usb_function_irq_enable_flags_tb
